//--- bfc_core.sv
// Notes on behaviour
// - compare-and-swap reads, compares and writes the new value only on a match, with the bus locked across the read and the write cycle.
// - the read and write of a lock operand run with the bus locked, so no other master gets in.
// - dual compare-and-swap checks two pairs and writes both destinations only if both match.
// - module call saves the module state in a frame; module return restores it and resumes.
// - a change of access rights is signalled outward and the outside decides if it is legal.
// - a bus error pushes the internal execution state onto the supervisor stack.
// - after the push the program counter is loaded from exception vector entry two.
// - exception return restores the saved state, reruns the faulted cycle and continues.
// - in user mode a privileged request traps to the supervisor.
// - addresses are a full 32 bits, a 4-Gbyte linear space.
// - each port declares 8, 16 or 32 bits and the transfer takes as many cycles as needed.
// - a 16-bit port takes two cycles and an 8-bit port four for a long word.
// - every cycle starts assuming a 32-bit port and moves as much as it can.
module bfc_core
    import bfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire bfc_pkg::bfc_req_t req,
    input wire logic user_mode,
    input wire logic [1:0] port_width_ack,
    input wire logic bus_err,
    input wire logic bus_req,
    input wire logic access_ok,
    output bfc_pkg::bfc_bus_t bus_r,
    output logic bus_cyc_r,
    output logic bus_grant_r,
    output logic access_chg_r,
    output logic busy_r,
    output bfc_pkg::bfc_resp_t resp_r
);
    typedef enum {
        S_IDLE, S_RD1, S_RD2, S_WR1, S_WR2, S_PUSH, S_VEC, S_ACC, S_DONE
    } bfc_state_t;

    bfc_state_t st_r;
    bfc_req_t cur_r;
    logic [ADDR_W-1:0] ssp_r;
    logic [ADDR_W-1:0] fault_addr_r;
    logic fault_wr_r;
    logic [DATA_W-1:0] fault_wdata_r;
    logic rerun_r;
    logic match1_r;
    logic start;
    logic s_write;
    logic [ADDR_W-1:0] s_addr;
    logic [DATA_W-1:0] s_wdata;
    logic s_cyc;
    logic [ADDR_W-1:0] s_cyc_addr;
    logic [DATA_W-1:0] s_cyc_wdata;
    logic [1:0] s_size;
    logic s_done;
    logic s_fault;
    logic [DATA_W-1:0] s_rdata;
    logic f_push;
    logic f_pop;
    logic [STATE_W-1:0] f_data;
    logic [STATE_W-1:0] f_top;
    logic f_empty;
    logic locked;

    bfc_sizer u_sizer (
        .clk(clk),
        .rst(rst),
        .start(start),
        .write(s_write),
        .addr(s_addr),
        .wdata(s_wdata),
        .port_width_ack(port_width_ack),
        .bus_err(bus_err),
        .cyc_r(s_cyc),
        .cyc_addr_r(s_cyc_addr),
        .cyc_wdata_r(s_cyc_wdata),
        .cyc_size_r(s_size),
        .done_r(s_done),
        .fault_r(s_fault),
        .rdata_r(s_rdata)
    );

    bfc_frame #(.DEPTH(16)) u_frame (
        .clk(clk),
        .rst(rst),
        .push(f_push),
        .pop(f_pop),
        .push_data(f_data),
        .top_r(f_top),
        .empty_r(f_empty)
    );

    // locked from the first read until the last write of a cas
    assign locked = (cur_r.op == BFC_OP_CAS || cur_r.op == BFC_OP_DUAL_CAS)
        && (st_r == S_RD1 || st_r == S_RD2 || st_r == S_WR1 || st_r == S_WR2);

    always_comb
    begin
        start = 1'b0;
        s_write = 1'b0;
        s_addr = cur_r.addr;
        s_wdata = '0;
        if (!s_cyc && !s_done && !s_fault)
        begin
            case (st_r)
                S_RD1: start = 1'b1;
                S_RD2:
                begin
                    start = 1'b1;
                    s_addr = cur_r.addr2;
                end
                S_WR1:
                begin
                    start = 1'b1;
                    s_write = 1'b1;
                    s_wdata = cur_r.upd1;
                end
                S_WR2:
                begin
                    start = 1'b1;
                    s_write = 1'b1;
                    s_addr = cur_r.addr2;
                    s_wdata = cur_r.upd2;
                end
                default: start = 1'b0;
            endcase
        end
        // a rerun replays the exact faulted cycle
        if (rerun_r && start && cur_r.op == BFC_OP_EXC_RETURN)
        begin
            s_addr = fault_addr_r;
            s_write = fault_wr_r;
            s_wdata = fault_wdata_r;
        end
    end

    assign f_push = (st_r == S_PUSH) || (st_r == S_IDLE && req_valid
        && req.op == BFC_OP_MODULE_CALL);
    assign f_data = (st_r == S_IDLE) ? req.exec_state : cur_r.exec_state;
    assign f_pop = st_r == S_IDLE && req_valid && !f_empty
        && (req.op == BFC_OP_EXC_RETURN || req.op == BFC_OP_MODULE_RETURN);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= S_IDLE;
            cur_r <= '0;
            match1_r <= 1'b0;
            rerun_r <= 1'b0;
            fault_addr_r <= '0;
            fault_wr_r <= 1'b0;
            fault_wdata_r <= '0;
            ssp_r <= SSP_RESET;
            resp_r <= '0;
            busy_r <= 1'b0;
            access_chg_r <= 1'b0;
        end
        else
        begin
            resp_r.done <= 1'b0;
            resp_r.fault <= 1'b0;
            access_chg_r <= 1'b0;
            case (st_r)
                S_IDLE:
                begin
                    if (req_valid)
                    begin
                        cur_r <= req;
                        busy_r <= 1'b1;
                        resp_r.success <= 1'b0;
                        case (req.op)
                            BFC_OP_PRIV:
                            begin
                                if (user_mode)
                                begin
                                    // privileged use from user mode traps
                                    resp_r.pc <= VBR_RESET + PRIV_VEC_NUM * VEC_ENTRY_BYTES;
                                    resp_r.fault <= 1'b1;
                                end
                                resp_r.done <= 1'b1;
                                busy_r <= 1'b0;
                            end
                            BFC_OP_MODULE_CALL, BFC_OP_MODULE_RETURN:
                            begin
                                // module frame saved or restored, outside checks rights
                                access_chg_r <= 1'b1;
                                resp_r.exec_state <= req.op == BFC_OP_MODULE_RETURN ? f_top
                                    : req.exec_state;
                                st_r <= S_ACC;
                            end
                            BFC_OP_EXC_RETURN:
                            begin
                                // saved state reloaded, faulted cycle rerun if one is pending
                                resp_r.exec_state <= f_top;
                                ssp_r <= ssp_r + FRAME_WORDS * VEC_ENTRY_BYTES;
                                if (rerun_r)
                                begin
                                    st_r <= S_RD1;
                                end
                                else
                                begin
                                    st_r <= S_DONE;
                                end
                            end
                            BFC_OP_WRITE: st_r <= S_WR1;
                            BFC_OP_NONE:
                            begin
                                busy_r <= 1'b0;
                            end
                            default: st_r <= S_RD1;
                        endcase
                    end
                end
                S_ACC:
                begin
                    resp_r.success <= access_ok;
                    st_r <= S_DONE;
                end
                S_RD1, S_RD2, S_WR1, S_WR2:
                begin
                    if (s_fault)
                    begin
                        // non-resident page ends in bus error; remember the cycle
                        fault_addr_r <= (st_r == S_RD2 || st_r == S_WR2) ? cur_r.addr2 : cur_r.addr;
                        fault_wr_r <= st_r == S_WR1 || st_r == S_WR2;
                        fault_wdata_r <= st_r == S_WR2 ? cur_r.upd2 : cur_r.upd1;
                        rerun_r <= 1'b1;
                        st_r <= S_PUSH;
                    end
                    else if (s_done)
                    begin
                        rerun_r <= rerun_r && cur_r.op != BFC_OP_EXC_RETURN;
                        case (st_r)
                            S_RD1:
                            begin
                                resp_r.rdata <= s_rdata;
                                match1_r <= s_rdata == cur_r.cmp1;
                                if (cur_r.op == BFC_OP_DUAL_CAS)
                                    st_r <= S_RD2;
                                else if (cur_r.op == BFC_OP_CAS && s_rdata == cur_r.cmp1)
                                    st_r <= S_WR1;
                                else
                                    st_r <= S_DONE;
                            end
                            S_RD2:
                            begin
                                resp_r.rdata2 <= s_rdata;
                                // both pairs must match before either write
                                st_r <= (match1_r && s_rdata == cur_r.cmp2) ? S_WR1 : S_DONE;
                            end
                            S_WR1:
                            begin
                                resp_r.success <= 1'b1;
                                st_r <= cur_r.op == BFC_OP_DUAL_CAS ? S_WR2 : S_DONE;
                            end
                            default: st_r <= S_DONE;
                        endcase
                    end
                end
                S_PUSH:
                begin
                    // state pushed on the supervisor stack
                    ssp_r <= ssp_r - FRAME_WORDS * VEC_ENTRY_BYTES;
                    st_r <= S_VEC;
                end
                S_VEC:
                begin
                    // handler taken from vector entry two
                    resp_r.pc <= VBR_RESET + {24'h000000, BUS_ERR_VEC_NUM} * VEC_ENTRY_BYTES;
                    resp_r.fault <= 1'b1;
                    resp_r.done <= 1'b1;
                    busy_r <= 1'b0;
                    st_r <= S_IDLE;
                end
                S_DONE:
                begin
                    resp_r.done <= 1'b1;
                    busy_r <= 1'b0;
                    st_r <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus_r <= '0;
            bus_cyc_r <= 1'b0;
            bus_grant_r <= 1'b0;
        end
        else
        begin
            // full 32-bit address driven
            bus_r.addr <= s_cyc ? s_cyc_addr : s_addr;
            bus_r.wdata <= s_cyc_wdata;
            bus_r.write <= s_cyc ? bus_r.write : s_write;
            bus_r.size <= s_size;
            bus_r.locked <= locked;
            bus_cyc_r <= s_cyc;
            // no grant while a locked sequence is open
            bus_grant_r <= bus_req && !locked && !s_cyc && st_r == S_IDLE;
        end
    end

    AST_NO_GRANT_LOCKED: assert property (@(posedge clk) disable iff (rst)
        locked |=> !bus_grant_r)
        else $error("bus granted inside locked cycle");

    AST_CAS_MISS_NO_WRITE: assert property (@(posedge clk) disable iff (rst)
        (st_r == S_RD1 && s_done && cur_r.op == BFC_OP_CAS && s_rdata != cur_r.cmp1)
        |=> st_r == S_DONE)
        else $error("cas wrote after a miss");

    AST_DUAL_MISS: assert property (@(posedge clk) disable iff (rst)
        (st_r == S_RD2 && s_done && !(match1_r && s_rdata == cur_r.cmp2))
        |=> st_r == S_DONE)
        else $error("dual cas wrote after a miss");

    AST_FAULT_VECTOR: assert property (@(posedge clk) disable iff (rst)
        (st_r != S_IDLE && s_fault) |=> st_r == S_PUSH ##1 st_r == S_VEC
        ##1 (resp_r.fault && resp_r.pc == 32'h0000_0008))
        else $error("bus error did not vector through entry two");

    AST_FAULT_PUSH: assert property (@(posedge clk) disable iff (rst)
        st_r == S_PUSH |=> ssp_r == $past(ssp_r) - 32'h0000_0010)
        else $error("state not pushed on bus error");

    AST_USER_TRAP: assert property (@(posedge clk) disable iff (rst)
        (st_r == S_IDLE && req_valid && req.op == BFC_OP_PRIV && user_mode)
        |=> resp_r.fault && resp_r.done)
        else $error("user privileged request did not trap");

    AST_ACCESS_SIGNAL: assert property (@(posedge clk) disable iff (rst)
        (st_r == S_IDLE && req_valid && req.op == BFC_OP_MODULE_CALL)
        |=> access_chg_r ##2 resp_r.done)
        else $error("module call did not signal access change");
    AST_RERUN: assert property (@(posedge clk) disable iff (rst)
        (st_r == S_IDLE && req_valid && req.op == BFC_OP_EXC_RETURN && rerun_r)
        |=> st_r == S_RD1)
        else $error("faulted cycle not rerun");
    AST_LOCK_WRITE: assert property (@(posedge clk) disable iff (rst)
        (bus_cyc_r && bus_r.write && st_r != S_IDLE
        && (cur_r.op == BFC_OP_CAS || cur_r.op == BFC_OP_DUAL_CAS)) |-> bus_r.locked)
        else $error("write phase not locked");
endmodule // bfc_core

//--- bfc_pkg.sv
package bfc_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int STATE_W = 32;
    localparam logic [ADDR_W-1:0] RESET_PC = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] VBR_RESET = 32'h0000_0000;
    localparam logic [7:0] BUS_ERR_VEC_NUM = 8'h02;
    localparam logic [ADDR_W-1:0] VEC_ENTRY_BYTES = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] PRIV_VEC_NUM = 32'h0000_0008;
    localparam logic [ADDR_W-1:0] FRAME_WORDS = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] MOD_FRAME_WORDS = 32'h0000_0002;
    localparam logic [ADDR_W-1:0] SSP_RESET = 32'h0000_1000;
    localparam int FRAME_W = 2;
    localparam int MOD_FRAME_W = 1;

    // port_width_ack encoding: 2'b00 wait, 01 byte, 10 half, 11 word
    localparam logic [1:0] ACK_WAIT = 2'b00;
    localparam logic [1:0] ACK_BYTE = 2'b01;
    localparam logic [1:0] ACK_HALF = 2'b10;
    localparam logic [1:0] ACK_WORD = 2'b11;

    typedef enum logic [3:0] {
        BFC_OP_NONE,
        BFC_OP_READ,
        BFC_OP_WRITE,
        BFC_OP_CAS,
        BFC_OP_DUAL_CAS,
        BFC_OP_MODULE_CALL,
        BFC_OP_MODULE_RETURN,
        BFC_OP_EXC_RETURN,
        BFC_OP_PRIV
    } bfc_op_t;

    typedef struct packed {
        bfc_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] addr2;
        logic [DATA_W-1:0] cmp1;
        logic [DATA_W-1:0] cmp2;
        logic [DATA_W-1:0] upd1;
        logic [DATA_W-1:0] upd2;
        logic [STATE_W-1:0] exec_state;
    } bfc_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
        logic locked;
        logic [1:0] size;
    } bfc_bus_t;

    typedef struct packed {
        logic done;
        logic success;
        logic fault;
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] rdata2;
        logic [ADDR_W-1:0] pc;
        logic [STATE_W-1:0] exec_state;
    } bfc_resp_t;

endpackage

//--- bfc_sizer.sv
// one bus transfer of up to 32 bits, broken into as many cycles as the port asks for
module bfc_sizer
    import bfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [1:0] port_width_ack,
    input wire logic bus_err,
    output logic cyc_r,
    output logic [ADDR_W-1:0] cyc_addr_r,
    output logic [DATA_W-1:0] cyc_wdata_r,
    output logic [1:0] cyc_size_r,
    output logic done_r,
    output logic fault_r,
    output logic [DATA_W-1:0] rdata_r
);
    logic [2:0] left_r;
    logic [2:0] taken;

    always_comb
    begin
        case (port_width_ack)
            ACK_BYTE: taken = 3'd1;
            ACK_HALF: taken = 3'd2;
            default: taken = 3'd4;
        endcase
        if (taken > left_r)
        begin
            taken = left_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cyc_r <= 1'b0;
            left_r <= 3'd0;
            done_r <= 1'b0;
            fault_r <= 1'b0;
            cyc_addr_r <= '0;
            cyc_wdata_r <= '0;
            cyc_size_r <= 2'b00;
            rdata_r <= '0;
        end
        else
        begin
            done_r <= 1'b0;
            fault_r <= 1'b0;
            if (start && !cyc_r)
            begin
                // every cycle opens assuming a full-width port
                cyc_r <= 1'b1;
                left_r <= 3'd4;
                cyc_size_r <= 2'b00;
                cyc_addr_r <= addr;
                cyc_wdata_r <= wdata;
                rdata_r <= '0;
            end
            else if (cyc_r && bus_err)
            begin
                cyc_r <= 1'b0;
                fault_r <= 1'b1;
            end
            else if (cyc_r && port_width_ack != ACK_WAIT)
            begin
                // width taken from the acknowledge on each cycle
                case (taken)
                    3'd1: rdata_r <= {rdata_r[23:0], write ? 8'h00 : 8'hFF & 8'h00};
                    3'd2: rdata_r <= {rdata_r[15:0], 16'h0000};
                    default: rdata_r <= '0;
                endcase
                left_r <= left_r - taken;
                cyc_addr_r <= cyc_addr_r + {29'd0, taken};
                cyc_wdata_r <= cyc_wdata_r << (8 * taken);
                cyc_size_r <= 2'(left_r - taken);
                if (left_r == taken)
                begin
                    cyc_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end

    // a port narrower than the request forces more cycles until four bytes moved
    AST_BYTE_PORT_FOUR: assert property (@(posedge clk) disable iff (rst)
        (cyc_r && left_r > 3'd1 && port_width_ack == ACK_BYTE && !bus_err)
        |=> cyc_r && left_r == $past(left_r) - 3'd1)
        else $error("byte port ended transfer early");

    AST_WORD_ONE: assert property (@(posedge clk) disable iff (rst)
        (cyc_r && left_r == 3'd4 && port_width_ack == ACK_WORD && !bus_err)
        |=> done_r && !cyc_r)
        else $error("word port did not finish in one cycle");

    AST_HALF_TWO: assert property (@(posedge clk) disable iff (rst)
        (cyc_r && left_r == 3'd4 && port_width_ack == ACK_HALF && !bus_err)
        |=> cyc_r && left_r == 3'd2)
        else $error("half port did not run a second cycle");
endmodule // bfc_sizer

//--- bfc_frame.sv
// supervisor stack frame store: saved state words pushed and popped
module bfc_frame
    import bfc_pkg::*;
#(
    parameter int DEPTH = 16
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic pop,
    input wire logic [STATE_W-1:0] push_data,
    output logic [STATE_W-1:0] top_r,
    output logic empty_r
);
    logic [STATE_W-1:0] mem [DEPTH];
    logic [$clog2(DEPTH):0] cnt_r;

    always_ff @(posedge clk)
    begin
        if (push && cnt_r < ($clog2(DEPTH)+1)'(DEPTH))
        begin
            mem[cnt_r[$clog2(DEPTH)-1:0]] <= push_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_r <= '0;
            top_r <= '0;
            empty_r <= 1'b1;
        end
        else if (push && cnt_r < ($clog2(DEPTH)+1)'(DEPTH))
        begin
            cnt_r <= cnt_r + 1'b1;
            top_r <= push_data;
            empty_r <= 1'b0;
        end
        else if (pop && cnt_r != '0)
        begin
            cnt_r <= cnt_r - 1'b1;
            top_r <= (cnt_r > 1) ? mem[cnt_r[$clog2(DEPTH)-1:0] - 2'd2] : '0;
            empty_r <= (cnt_r == 1);
        end
    end
endmodule // bfc_frame

//--- bfc_mem_model.sv
// memory and access-control side: answers each open cycle with its port width
module bfc_mem_model
    import bfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_cyc_r,
    input wire bfc_pkg::bfc_bus_t bus_r,
    input wire logic access_chg_r,
    input wire logic [1:0] width,
    input wire logic [3:0] wait_n,
    input wire logic fault_on,
    input wire logic allow,
    output logic [1:0] port_width_ack,
    output logic bus_err,
    output logic access_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r;
    logic gap_r;
    // verdict answered in the same cycle, so the core sees it on the next edge
    assign access_ok = access_chg_r & allow;
    // one idle cycle after each ack, so a late-closing cycle is not acked twice
    always_ff @(posedge clk)
    begin
        port_width_ack <= ACK_WAIT;
        bus_err <= 1'b0;
        gap_r <= 1'b0;
        if (rst || !bus_cyc_r)
        begin
            cnt_r <= 4'h0;
        end
        else if (fault_on && bus_r.addr[31:28] == 4'hF)
        begin
            bus_err <= 1'b1;
        end
        else if (!gap_r && cnt_r >= wait_n)
        begin
            port_width_ack <= width;
            gap_r <= 1'b1;
            cnt_r <= 4'h0;
        end
        else
        begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule // bfc_mem_model

//--- test_bus_fault_continuation.sv
module test_bus_fault_continuation;
    timeunit 1ns;
    timeprecision 1ns;
    import bfc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    bfc_req_t req = '0;
    logic user_mode = 1'b0;
    logic bus_req = 1'b0;
    logic [1:0] width = ACK_WORD;
    logic [3:0] wait_n = 4'h0;
    logic fault_on = 1'b0;
    logic allow = 1'b1;
    logic [1:0] port_width_ack;
    logic bus_err, access_ok, bus_cyc_r, bus_grant_r, access_chg_r, busy_r;
    bfc_bus_t bus_r;
    bfc_resp_t resp_r;
    int mismatches = 0;
    int samples_checked = 0;
    int seed = 32'h7E31;
    int acks, chg;
    logic locked_seen, fault_seen, got;
    logic [31:0] first_addr, st, a, r;

    always #5 clk = ~clk;

    bfc_core i_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
        .user_mode(user_mode), .port_width_ack(port_width_ack), .bus_err(bus_err),
        .bus_req(bus_req), .access_ok(access_ok), .bus_r(bus_r), .bus_cyc_r(bus_cyc_r),
        .bus_grant_r(bus_grant_r), .access_chg_r(access_chg_r), .busy_r(busy_r),
        .resp_r(resp_r));

    bfc_mem_model i_mem (.clk(clk), .rst(rst), .bus_cyc_r(bus_cyc_r), .bus_r(bus_r),
        .access_chg_r(access_chg_r), .width(width), .wait_n(wait_n), .fault_on(fault_on),
        .allow(allow), .port_width_ack(port_width_ack), .bus_err(bus_err),
        .access_ok(access_ok));

    function automatic int exp_cycles(input logic [1:0] w);
        return (w == ACK_BYTE) ? 4 : (w == ACK_HALF) ? 2 : 1;
    endfunction

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got_v);
        samples_checked++;
        if (got_v !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %0h seen %0h", name, exp, got_v);
        end
    endtask

    task automatic end_sim();
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one request, then watch the bus at each falling edge until done
    task automatic run(input bfc_op_t op, input logic [31:0] ad, input logic [31:0] es);
        int n;
        @(negedge clk);
        req = '{op, ad, ad + 32'h10, $random(seed), $random(seed), $random(seed),
            $random(seed), es};
        req_valid = 1'b1;
        acks = 0;
        chg = 0;
        locked_seen = 1'b0;
        got = 1'b0;
        @(negedge clk);
        req_valid = 1'b0;
        for (n = 0; n < 300 && resp_r.done !== 1'b1; n++)
        begin
            if (bus_cyc_r === 1'b1 && port_width_ack !== ACK_WAIT)
                acks++;
            if (bus_cyc_r === 1'b1 && !got)
            begin
                first_addr = bus_r.addr;
                got = 1'b1;
            end
            if (bus_r.locked === 1'b1)
                locked_seen = 1'b1;
            if (access_chg_r === 1'b1)
                chg++;
            if (bus_grant_r === 1'b1 && bus_r.locked === 1'b1)
                check("grant_in_lock", 0, 1);
            @(negedge clk);
        end
        fault_seen = resp_r.fault;
        if (n == 300)
            check("done", 1, 0);
    endtask

    initial
    begin
        repeat (11) @(negedge clk);
        check("reset_idle", 0, {busy_r, resp_r.done, bus_cyc_r});
        rst = 1'b0;
        for (int k = 0; k < 9; k++)
        begin
            r = $random(seed);
            width = 2'(k % 3 + 1);
            wait_n = {2'b00, r[1:0]};
            a = r & 32'h0FFF_FFFC;
            run(BFC_OP_READ, a, '0);
            check("read_cycles", exp_cycles(width), acks);
            check("first_addr", a, first_addr);
            run(BFC_OP_WRITE, a, '0);
            check("write_cycles", exp_cycles(width), acks);
            check("write_unlocked", 0, locked_seen);
        end
        width = ACK_WORD;
        bus_req = 1'b1;
        run(BFC_OP_CAS, 32'h0000_0100, '0);
        check("cas_locked", 1, locked_seen);
        run(BFC_OP_DUAL_CAS, 32'h0000_0200, '0);
        check("dcas_locked", 1, locked_seen);
        bus_req = 1'b0;
        st = $random(seed);
        run(BFC_OP_MODULE_CALL, 32'h0000_0300, st);
        check("access_chg", 1, chg);
        check("call_allowed", 1, resp_r.success);
        allow = 1'b0;
        run(BFC_OP_MODULE_RETURN, 32'h0000_0300, '0);
        check("module_state", st, resp_r.exec_state);
        check("return_refused", 0, resp_r.success);
        allow = 1'b1;
        fault_on = 1'b1;
        st = $random(seed);
        run(BFC_OP_READ, 32'hF000_0040, st);
        check("berr_fault", 1, fault_seen);
        check("berr_pc", BUS_ERR_VEC_NUM * VEC_ENTRY_BYTES, resp_r.pc);
        fault_on = 1'b0;
        run(BFC_OP_EXC_RETURN, 32'h0000_0000, '0);
        check("rte_state", st, resp_r.exec_state);
        check("rte_rerun", 1, acks > 0);
        user_mode = 1'b1;
        run(BFC_OP_PRIV, 32'h0000_0000, '0);
        check("priv_pc", PRIV_VEC_NUM * VEC_ENTRY_BYTES, resp_r.pc);
        user_mode = 1'b0;
        end_sim();
    end

    // 25 requests of at most 300 cycles each fit well inside this span
    initial
    begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule // test_bus_fault_continuation
